// ==== ais_pkg.sv ====
// shared constants, types and states of the acquisition instruction sequencer
package ais_pkg;
   // ------------------------------------------------------------
   // register addresses on the parallel bus (A4..A1)
   // ------------------------------------------------------------
   localparam logic [3:0] ADDR_CONFIG = 4'h8; // configuration register
   localparam logic [3:0] ADDR_STATUS = 4'hA; // sequencer address readback
   localparam logic [3:0] ADDR_TIMER = 4'hB; // timer preset
   localparam int RAM_SEL_BIT = 3; // address bit that leaves the instruction ram
   localparam int NUM_INSTR = 8; // instructions held
   localparam int NUM_SECT = 3; // 16-bit sections per instruction
   localparam logic [2:0] LAST_INSTR = 3'h7; // highest instruction address
   localparam logic [2:0] FIRST_INSTR = 3'h0; // sequence start
   // ------------------------------------------------------------
   // configuration register fields
   // ------------------------------------------------------------
   localparam int CFG_START = 0; // start / running status
   localparam int CFG_RESET = 1; // soft reset, self clearing
   localparam int CFG_IO_SEL = 7; // trigger pin direction, 1 = output
   localparam int CFG_PTR_LO = 8; // section pointer low bit
   localparam int CFG_PTR_HI = 9; // section pointer high bit
   localparam logic [15:0] CFG_RESET_VAL = 16'h0000;
   localparam logic [15:0] CFG_KEEP_MASK = 16'h0FFD; // reset bit never stored
   localparam logic [1:0] PTR_CONTROL = 2'h0; // control section
   localparam int STAT_ADDR_LO = 8; // sequencer address in status word
   // ------------------------------------------------------------
   // control section fields
   // ------------------------------------------------------------
   localparam int INS_LOOP = 0;
   localparam int INS_PAUSE = 1;
   localparam int INS_POS_LO = 2;
   localparam int INS_NEG_LO = 5;
   localparam int INS_SYNC = 8;
   localparam int INS_TIMER = 9;
   localparam int INS_RES8 = 10;
   localparam int INS_WATCH = 11;
   localparam logic [2:0] NEG_GROUND = 3'h0; // inverting input tied to ground
   // decoded control section
   typedef struct packed {
      logic loop;
      logic pause;
      logic [2:0] positive_input_select;
      logic [2:0] negative_input_select;
      logic neg_ground;
      logic sync_wait;
      logic timer_wait;
      logic res8;
      logic watch;
   } ais_instr_t;
   // sequencer states
   typedef enum logic [3:0] {
      ST_FETCH, ST_DECODE, ST_WAIT_START, ST_TIMER, ST_ACQ, ST_SYNC,
      ST_CONV, ST_CONV_WAIT, ST_NEXT
   } ais_state_t;
endpackage

// ==== ais_decode.sv ====
// control section decoder of the acquisition instruction sequencer
`timescale 1ns/1ps
`default_nettype none
module ais_decode
   import ais_pkg::*;
(
   input wire logic [15:0] word_i, // raw control section
   output var ais_instr_t instr_o // decoded fields
);
   // ------------------------------------------------------------
   // field split
   // ------------------------------------------------------------
   always_comb begin
      instr_o.loop = word_i[INS_LOOP];
      instr_o.pause = word_i[INS_PAUSE];
      instr_o.positive_input_select = word_i[INS_POS_LO +: 3];
      instr_o.negative_input_select = word_i[INS_NEG_LO +: 3];
      instr_o.neg_ground = (word_i[INS_NEG_LO +: 3] == NEG_GROUND);
      instr_o.sync_wait = word_i[INS_SYNC];
      instr_o.timer_wait = word_i[INS_TIMER];
      instr_o.res8 = word_i[INS_RES8];
      instr_o.watch = word_i[INS_WATCH];
   end
endmodule
`default_nettype wire

// ==== ais_sequencer.sv ====
// instruction ram, configuration register and event sequencer
// Overview of operation
// - loop bit ends sequence, next is instruction zero
// - pause bit halts before execute, clears start
// - pause halt raises pause interrupt source five
// - soft reset fetches instruction zero, awaits start
// - first instruction zero run ignores pause
// - after wrap, pause in instruction zero halts
// - bits 2-4 pick non-inverting channel
// - bits 5-7 pick inverting channel, 000 ground
// - sync bit waits trigger edge after acquisition
// - window compare with sync needs two trigger edges
// - timer bit halts until down-counter zero
// - bit 10 picks eight or twelve bits
// - bit 11 chooses two comparisons or conversion
// - config bits 8-9 select instruction section
`timescale 1ns/1ps
`default_nettype none
module ais_sequencer
   import ais_pkg::*;
(
   input wire logic CLK_I, // converter clock
   input wire logic RST_I, // async reset, active high
   input wire logic CS_N_I, // chip select, active low
   input wire logic RD_N_I, // read strobe, active low
   input wire logic WR_N_I, // write strobe, active low
   input wire logic [3:0] ADDR_I, // word address A4..A1
   input wire logic [15:0] DATA_I, // write data
   output logic [15:0] DATA_O, // read data
   input wire logic SYNC_I, // trigger pin level
   output logic SYNC_O, // trigger pin drive
   output logic SYNC_OE_O, // trigger pin enable
   input wire logic ACQ_DONE_I, // acquisition interval over
   input wire logic CONV_DONE_I, // conversion or comparison finished
   input wire logic TIMER_ZERO_I, // down-counter reached zero
   output logic ACQ_START_O, // pulse: begin acquisition
   output logic CONV_START_O, // pulse: sample and convert/compare
   output logic TIMER_START_O, // pulse: reload and run timer
   output logic PAUSE_INT_O, // pulse: pause interrupt source
   output logic [2:0] POS_SEL_O, // non-inverting channel
   output logic [2:0] NEG_SEL_O, // inverting channel
   output logic NEG_GND_O, // inverting input on ground
   output logic RES8_O, // 1 = 8 bits plus sign
   output logic WATCH_O, // 1 = window comparison
   output logic LIMIT2_O, // 1 = second limit in use
   output logic [15:0] TIMER_PRESET_O, // timer preset value
   output logic [2:0] SEQ_ADDR_O // instruction being handled
);
   // ------------------------------------------------------------
   // storage and state
   // ------------------------------------------------------------
   logic [15:0] ram [0:NUM_INSTR*NUM_SECT-1]; // three sections per instruction
   logic [15:0] cfg_reg, cfg_next; // configuration register
   logic [15:0] timer_reg, timer_next; // timer preset
   logic [15:0] rdata_reg, rdata_next; // read data
   ais_state_t state_reg, state_next; // sequencer state
   logic [2:0] addr_reg, addr_next; // instruction address
   logic [15:0] word_reg, word_next; // fetched control section
   logic first_reg, first_next; // first run of instruction zero pending
   logic second_reg, second_next; // second comparison under way
   logic sync_prev_reg; // trigger level last cycle
   logic neg_gnd_reg, neg_gnd_next; // ground flag, taken at decode so the pin comes from a flop
   logic [3:0] pulse_reg, pulse_next; // acq, conv, timer, int strobes
   ais_instr_t instr; // decoded current instruction
   logic wr_en, rd_en, soft_reset, ram_hit, sync_rise;
   logic [1:0] ptr;
   logic [4:0] ram_idx;

   // single decoder for the fetched word
   ais_decode u_decode (
      .word_i(word_reg),
      .instr_o(instr)
   );

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   // index into the flat ram from pointer and instruction address
   function automatic logic [4:0] ram_index(input logic [1:0] p, input logic [2:0] a);
      ram_index = {p, a};
   endfunction

   assign wr_en = !CS_N_I && !WR_N_I;
   assign rd_en = !CS_N_I && !RD_N_I;
   assign ptr = cfg_reg[CFG_PTR_HI:CFG_PTR_LO];
   // pointer value 11 has no section behind it
   assign ram_hit = !ADDR_I[RAM_SEL_BIT] && (ptr != 2'h3);
   assign ram_idx = ram_index(ptr, ADDR_I[2:0]);
   assign soft_reset = wr_en && (ADDR_I == ADDR_CONFIG) && DATA_I[CFG_RESET];
   assign sync_rise = SYNC_I && !sync_prev_reg; // pin is synchronous already

   // ram writes; no reset so the array stays a plain memory
   always_ff @(posedge CLK_I) begin
      if (wr_en && ram_hit) begin
         ram[ram_idx] <= DATA_I;
      end
   end

   // ------------------------------------------------------------
   // register file next values
   // ------------------------------------------------------------
   always_comb begin
      cfg_next = cfg_reg;
      timer_next = timer_reg;
      rdata_next = rdata_reg;
      // hardware clears start on a pause halt
      if (state_reg == ST_DECODE && instr.pause && !first_reg) begin
         cfg_next[CFG_START] = 1'b0;
      end
      // host write comes last so a start written now wins the clear
      if (wr_en && ADDR_I == ADDR_CONFIG) begin
         cfg_next = DATA_I & CFG_KEEP_MASK;
      end
      if (wr_en && ADDR_I == ADDR_TIMER) begin
         timer_next = DATA_I;
      end
      if (rd_en) begin
         if (ram_hit) begin
            rdata_next = ram[ram_idx];
         end else if (ADDR_I == ADDR_CONFIG) begin
            rdata_next = cfg_reg;
         end else if (ADDR_I == ADDR_STATUS) begin
            rdata_next = 16'h0000;
            rdata_next[STAT_ADDR_LO +: 3] = addr_reg;
         end else if (ADDR_I == ADDR_TIMER) begin
            rdata_next = timer_reg;
         end else begin
            rdata_next = 16'h0000; // unmapped reads zero
         end
      end
   end

   // ------------------------------------------------------------
   // sequencer next values
   // ------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      addr_next = addr_reg;
      word_next = word_reg;
      first_next = first_reg;
      second_next = second_reg;
      neg_gnd_next = neg_gnd_reg;
      pulse_next = 4'h0;
      case (state_reg)
         // read control section of the current address
         ST_FETCH: begin
            word_next = ram[ram_index(PTR_CONTROL, addr_reg)];
            state_next = ST_DECODE;
         end
         // pause check happens after fetch, before any execution
         ST_DECODE: begin
            neg_gnd_next = instr.neg_ground;
            if (instr.pause && !first_reg) begin
               pulse_next[3] = 1'b1;
               state_next = ST_WAIT_START;
            end else if (!cfg_reg[CFG_START]) begin
               state_next = ST_WAIT_START;
            end else begin
               state_next = instr.timer_wait ? ST_TIMER : ST_ACQ;
               pulse_next[2] = instr.timer_wait;
               pulse_next[0] = !instr.timer_wait;
            end
         end
         // halted until host sets start
         ST_WAIT_START: begin
            if (cfg_reg[CFG_START]) begin
               state_next = instr.timer_wait ? ST_TIMER : ST_ACQ;
               pulse_next[2] = instr.timer_wait;
               pulse_next[0] = !instr.timer_wait;
            end
         end
         // nothing is converted or compared while the timer runs
         ST_TIMER: begin
            if (TIMER_ZERO_I) begin
               state_next = ST_ACQ;
               pulse_next[0] = 1'b1;
            end
         end
         // acquisition interval
         ST_ACQ: begin
            if (ACQ_DONE_I) begin
               state_next = instr.sync_wait ? ST_SYNC : ST_CONV;
            end
         end
         // wait for a trigger edge, convert on the next clock
         ST_SYNC: begin
            if (sync_rise) begin
               state_next = ST_CONV;
            end
         end
         // one conversion, or one of two comparisons
         ST_CONV: begin
            pulse_next[1] = 1'b1;
            state_next = ST_CONV_WAIT;
         end
         ST_CONV_WAIT: begin
            if (CONV_DONE_I) begin
               if (instr.watch && !second_reg) begin
                  second_next = 1'b1;
                  state_next = instr.sync_wait ? ST_SYNC : ST_CONV;
               end else begin
                  second_next = 1'b0;
                  state_next = ST_NEXT;
               end
            end
         end
         // step to the next address, wrapping on loop or at the end
         ST_NEXT: begin
            if (addr_reg == FIRST_INSTR) begin
               first_next = 1'b0;
            end
            if (instr.loop || addr_reg == LAST_INSTR) begin
               addr_next = FIRST_INSTR;
            end else begin
               addr_next = addr_reg + 3'h1;
            end
            state_next = ST_FETCH;
         end
         default: begin
            state_next = ST_FETCH;
         end
      endcase
      // soft reset restarts from instruction zero
      if (soft_reset) begin
         state_next = ST_FETCH;
         addr_next = FIRST_INSTR;
         first_next = 1'b1;
         second_next = 1'b0;
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         cfg_reg <= CFG_RESET_VAL;
         timer_reg <= 16'h0000;
         rdata_reg <= 16'h0000;
         state_reg <= ST_FETCH;
         addr_reg <= FIRST_INSTR;
         word_reg <= 16'h0000;
         first_reg <= 1'b1;
         second_reg <= 1'b0;
         sync_prev_reg <= 1'b0;
         neg_gnd_reg <= 1'b1;
         pulse_reg <= 4'h0;
      end else begin
         cfg_reg <= cfg_next;
         timer_reg <= timer_next;
         rdata_reg <= rdata_next;
         state_reg <= state_next;
         addr_reg <= addr_next;
         word_reg <= word_next;
         first_reg <= first_next;
         second_reg <= second_next;
         sync_prev_reg <= SYNC_I;
         neg_gnd_reg <= neg_gnd_next;
         pulse_reg <= pulse_next;
      end
   end

   // ------------------------------------------------------------
   // outputs straight from flops
   // ------------------------------------------------------------
   always_comb begin
      DATA_O = rdata_reg;
      ACQ_START_O = pulse_reg[0];
      CONV_START_O = pulse_reg[1];
      TIMER_START_O = pulse_reg[2];
      PAUSE_INT_O = pulse_reg[3];
      SYNC_O = pulse_reg[1]; // conversion start mirrored when pin is output
      SYNC_OE_O = cfg_reg[CFG_IO_SEL];
      POS_SEL_O = instr.positive_input_select;
      NEG_SEL_O = instr.negative_input_select;
      NEG_GND_O = neg_gnd_reg;
      RES8_O = instr.res8;
      WATCH_O = instr.watch;
      LIMIT2_O = second_reg;
      TIMER_PRESET_O = timer_reg;
      SEQ_ADDR_O = addr_reg;
   end
endmodule
`default_nettype wire

// ==== ais_seq_monitor.sv ====
// checker bound to the sequencer ports
`timescale 1ns/1ps
`default_nettype none
module ais_seq_monitor
   import ais_pkg::*;
(
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic SYNC_I,
   input wire logic ACQ_DONE_I,
   input wire logic CONV_DONE_I,
   input wire logic ACQ_START_O,
   input wire logic CONV_START_O,
   input wire logic TIMER_START_O,
   input wire logic PAUSE_INT_O,
   input wire logic [2:0] POS_SEL_O,
   input wire logic [2:0] NEG_SEL_O,
   input wire logic NEG_GND_O,
   input wire logic WATCH_O,
   input wire logic LIMIT2_O,
   input wire logic [2:0] SEQ_ADDR_O
);
   // ------------------------------------------------------------
   // properties, all on the converter clock
   // ------------------------------------------------------------
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   a_neg_ground: assert property (ACQ_START_O |-> NEG_GND_O == (NEG_SEL_O == 3'h0))
      else $error("ground flag disagrees with inverting select");
   a_seq_step: assert property ($changed(SEQ_ADDR_O) |->
      (SEQ_ADDR_O == 3'h0) || (SEQ_ADDR_O == $past(SEQ_ADDR_O) + 3'h1))
      else $error("sequencer address skipped");
   a_timer_hold: assert property (TIMER_START_O |=> (!ACQ_START_O && !CONV_START_O)[*2])
      else $error("activity while timer runs");
   a_limit_pair: assert property (CONV_START_O && LIMIT2_O |-> WATCH_O)
      else $error("second limit outside window mode");
   a_conv_cause: assert property (CONV_START_O |-> $past(ACQ_DONE_I, 2) ||
      $past(CONV_DONE_I, 2) || ($past(SYNC_I, 2) && !$past(SYNC_I, 3)))
      else $error("conversion start without cause");
   a_sel_stable: assert property (ACQ_START_O |=>
      ($stable(POS_SEL_O) && $stable(NEG_SEL_O))[*2])
      else $error("channel select moved during acquisition");
   a_pause_hold: assert property (PAUSE_INT_O |=> (!ACQ_START_O && !TIMER_START_O)[*8])
      else $error("sequencer ran on after pause");
   a_pause_pulse: assert property (PAUSE_INT_O |=> !PAUSE_INT_O)
      else $error("pause source longer than one cycle");
endmodule
bind ais_sequencer ais_seq_monitor ais_seq_monitor_i (.CLK_I(CLK_I), .RST_I(RST_I),
   .SYNC_I(SYNC_I), .ACQ_DONE_I(ACQ_DONE_I), .CONV_DONE_I(CONV_DONE_I),
   .ACQ_START_O(ACQ_START_O), .CONV_START_O(CONV_START_O), .TIMER_START_O(TIMER_START_O),
   .PAUSE_INT_O(PAUSE_INT_O), .POS_SEL_O(POS_SEL_O), .NEG_SEL_O(NEG_SEL_O),
   .NEG_GND_O(NEG_GND_O), .WATCH_O(WATCH_O), .LIMIT2_O(LIMIT2_O), .SEQ_ADDR_O(SEQ_ADDR_O));
`default_nettype wire

// ==== ais_far_model.sv ====
// behavioural converter, timer and trigger source
`timescale 1ns/1ps
`default_nettype none
module ais_far_model
   import ais_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic acq_start_i,
   input wire logic conv_start_i,
   input wire logic timer_start_i,
   input wire logic watch_i,
   input wire logic limit2_i,
   input wire logic [2:0] seq_addr_i,
   input wire logic [7:0] sync_mask_i,
   output logic acq_done_o,
   output logic conv_done_o,
   output logic timer_zero_o,
   output logic sync_o
);
   logic [2:0] acq_cnt, conv_cnt, tmr_cnt, syn_cnt; // random answer delays, trigger countdown fixed at 4
   logic trig; // a fresh trigger edge is owed
   // edges only when the sequencer waits, so a stray edge never hides a bug
   assign trig = sync_mask_i[seq_addr_i] && ((acq_cnt == 3'h1) ||
      ((conv_cnt == 3'h1) && watch_i && !limit2_i));
   // ------------------------------------------------------------
   // countdowns, done pulses one cycle, trigger high two cycles
   // ------------------------------------------------------------
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         {acq_cnt, conv_cnt, tmr_cnt, syn_cnt} <= 12'h000;
         {acq_done_o, conv_done_o, timer_zero_o, sync_o} <= 4'h0;
      end else begin
         acq_cnt <= acq_start_i ? 3'(2 + $urandom_range(3)) : acq_cnt - 3'(acq_cnt != 0);
         conv_cnt <= conv_start_i ? 3'(2 + $urandom_range(3)) : conv_cnt - 3'(conv_cnt != 0);
         tmr_cnt <= timer_start_i ? 3'(2 + $urandom_range(3)) : tmr_cnt - 3'(tmr_cnt != 0);
         syn_cnt <= trig ? 3'h4 : syn_cnt - 3'(syn_cnt != 0);
         acq_done_o <= (acq_cnt == 3'h1);
         conv_done_o <= (conv_cnt == 3'h1);
         timer_zero_o <= (tmr_cnt == 3'h1);
         sync_o <= (syn_cnt == 3'h3) || (syn_cnt == 3'h2);
      end
   end
endmodule
`default_nettype wire

// ==== acq_instruction_sequencer_tb_top.sv ====
// self-checking testbench of the acquisition instruction sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; $display("BAD %0t got %h want %h", $time, g, e); end end
module acq_instruction_sequencer_tb_top
   import ais_pkg::*;
;
   logic clk_i, rst_i, cs_n, rd_n, wr_n, rd_pend, sync_i, acq_done, conv_done, tmr_zero;
   logic acq_st, conv_st, tmr_st, pause_int, sync_o, sync_oe, neg_gnd, res8, watch, limit2;
   logic [3:0] addr;
   logic [15:0] wdata, rdata, tpreset, tval, rd_exp;
   logic [14:0] ev_exp; // oldest noted event, popped once per result
   logic [2:0] pos_sel, neg_sel, seq_addr;
   logic [7:0] sync_mask; // instructions that wait for a trigger edge
   logic [15:0] prog [8]; // control sections as programmed
   logic [14:0] evq [$]; // expected events, oldest first
   logic [15:0] rdq [$]; // expected read data
   int err_total, n_checks;
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   ais_sequencer ais_sequencer_i (.CLK_I(clk_i), .RST_I(rst_i), .CS_N_I(cs_n), .RD_N_I(rd_n),
      .WR_N_I(wr_n), .ADDR_I(addr), .DATA_I(wdata), .DATA_O(rdata), .SYNC_I(sync_i),
      .SYNC_O(sync_o), .SYNC_OE_O(sync_oe), .ACQ_DONE_I(acq_done), .CONV_DONE_I(conv_done),
      .TIMER_ZERO_I(tmr_zero), .ACQ_START_O(acq_st), .CONV_START_O(conv_st),
      .TIMER_START_O(tmr_st), .PAUSE_INT_O(pause_int), .POS_SEL_O(pos_sel), .NEG_SEL_O(neg_sel),
      .NEG_GND_O(neg_gnd), .RES8_O(res8), .WATCH_O(watch), .LIMIT2_O(limit2),
      .TIMER_PRESET_O(tpreset), .SEQ_ADDR_O(seq_addr));
   ais_far_model ais_far_model_i (.clk_i(clk_i), .rst_i(rst_i), .acq_start_i(acq_st),
      .conv_start_i(conv_st), .timer_start_i(tmr_st), .watch_i(watch), .limit2_i(limit2),
      .seq_addr_i(seq_addr), .sync_mask_i(sync_mask), .acq_done_o(acq_done),
      .conv_done_o(conv_done), .timer_zero_o(tmr_zero), .sync_o(sync_i));
   // ------------------------------------------------------------
   // event words: kind, address, then the decoded fields
   // ------------------------------------------------------------
   function automatic logic [14:0] ev(input logic [1:0] k, input logic [2:0] a,
      input logic [15:0] w, input logic l2);
      ev = {k, a, (k == 2'h3) ? 10'h000 : {w[4:2], w[7:5], w[7:5] == 3'h0, w[10], w[11], l2}};
   endfunction
   function automatic logic [14:0] obs_ev();
      logic [1:0] k;
      k = pause_int ? 2'h3 : tmr_st ? 2'h2 : conv_st ? 2'h1 : 2'h0;
      obs_ev = {k, seq_addr, pause_int ? 10'h000 : {pos_sel, neg_sel, neg_gnd, res8, watch, limit2}};
   endfunction
   // one pass from instruction zero until the pause in instruction zero halts it
   task automatic expect_run();
      int a;
      a = 0;
      do begin
         if (prog[a][9]) evq.push_back(ev(2'h2, 3'(a), prog[a], 1'b0));
         evq.push_back(ev(2'h0, 3'(a), prog[a], 1'b0));
         evq.push_back(ev(2'h1, 3'(a), prog[a], 1'b0));
         if (prog[a][11]) evq.push_back(ev(2'h1, 3'(a), prog[a], 1'b1));
         a = prog[a][0] ? 0 : (a + 1) % NUM_INSTR;
      end while (a != 0 || !prog[0][1]);
      evq.push_back(ev(2'h3, 3'h0, prog[0], 1'b0));
   endtask
   task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_i);
      {cs_n, wr_n, addr, wdata} <= {2'b00, a, d};
      @(posedge clk_i);
      {cs_n, wr_n} <= 2'b11;
   endtask
   task automatic bus_rd(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_i);
      {cs_n, rd_n, addr} <= {2'b00, a};
      rdq.push_back(d);
      @(posedge clk_i);
      {cs_n, rd_n, rd_pend} <= 3'b111;
      @(posedge clk_i);
      rd_pend <= 1'b0;
   endtask
   // bounded wait until every noted event was seen
   task automatic drain(input string name);
      for (int i = 0; i < 3000 && evq.size() != 0; i++) @(posedge clk_i);
      if (evq.size() != 0) begin
         err_total++;
         $display("BAD %0t events missing in %s", $time, name);
      end
      repeat (10) @(posedge clk_i);
      $display("test %s done", name);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // ------------------------------------------------------------
   // result watcher: oldest note against each result
   // ------------------------------------------------------------
   always @(posedge clk_i) begin
      // pop into a variable first: the macro names its expected value twice
      if (rd_pend) begin
         rd_exp = rdq.pop_front();
         `CHK(rdata, rd_exp)
      end
      if (!rst_i && (acq_st || conv_st || tmr_st || pause_int)) begin
         `CHK(sync_o, conv_st)
         if (evq.size() == 0) begin
            err_total++;
            $display("BAD %0t unexpected event", $time);
         end else begin
            ev_exp = evq.pop_front();
            `CHK(obs_ev(), ev_exp)
         end
      end
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      err_total++;
      $display("BAD %0t run hung", $time);
      final_report();
   end
   initial begin
      {cs_n, rd_n, wr_n, rd_pend, rst_i, sync_mask, addr, wdata} = {5'h1D, 28'h0};
      err_total = 0;
      n_checks = 0;
      void'($urandom(73));
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      bus_rd(ADDR_CONFIG, CFG_RESET_VAL);
      bus_rd(4'hC, 16'h0000); // unmapped place reads zero
      // every positive and negative code once, random acquisition bits
      for (int k = 0; k < NUM_INSTR; k++) prog[k] = (16'($urandom) & 16'hF000) | 16'(k << 2) | 16'((7 - k) << 5);
      prog[0] |= 16'h0002; // pause in instruction zero
      prog[1] |= 16'h0800; // window compare, free running
      prog[2] |= 16'h0200; // timer wait
      prog[3] |= 16'h0D00; // window compare on trigger edges, short result
      prog[5] |= 16'h0100; // conversion on a trigger edge
      for (int k = 0; k < NUM_INSTR; k++) sync_mask[k] = prog[k][8];
      bus_wr(ADDR_CONFIG, 16'h0080); // trigger pin as output
      @(posedge clk_i);
      `CHK(sync_oe, 1'b1)
      bus_wr(ADDR_CONFIG, 16'h0000); // trigger pin as input
      @(posedge clk_i);
      `CHK(sync_oe, 1'b0)
      for (int k = 0; k < NUM_INSTR; k++) bus_wr(4'(k), prog[k]);
      bus_wr(ADDR_CONFIG, 16'h0100);
      bus_wr(4'h1, 16'h5A3C);
      bus_rd(4'h1, 16'h5A3C);
      bus_rd(ADDR_CONFIG, 16'h0100);
      bus_wr(ADDR_CONFIG, 16'h0000);
      bus_rd(4'h1, prog[1]); // control section untouched
      $display("test bus done");
      bus_wr(ADDR_CONFIG, 16'h0002); // soft reset after ram access
      repeat (20) @(posedge clk_i); // any event here is unexpected
      expect_run();
      bus_wr(ADDR_CONFIG, 16'h0001);
      bus_rd(ADDR_CONFIG, 16'h0001);
      drain("first run");
      bus_rd(ADDR_CONFIG, 16'h0000);
      bus_rd(ADDR_STATUS, 16'h0000);
      expect_run();
      bus_wr(ADDR_CONFIG, 16'h0001); // host resumes
      drain("resume");
      prog[2] |= 16'h0001;
      bus_wr(4'h2, prog[2]);
      bus_wr(ADDR_CONFIG, 16'h0002);
      expect_run();
      bus_wr(ADDR_CONFIG, 16'h0001);
      drain("loop");
      tval = 16'($urandom);
      bus_wr(ADDR_TIMER, tval);
      @(posedge clk_i);
      `CHK(tpreset, tval)
      $display("test timer done");
      final_report();
   end
endmodule
`default_nettype wire
